// File: rtl/spn_link_reset.sv
// link reset, oob start and speed negotiation sequencer for one port
`timescale 1ns/1ps
`default_nettype none
module spn_link_reset (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hard_reset_rx,
   input wire logic hard_reset_done,
   input wire logic other_hard_reset,
   input wire logic sync_lost,
   input wire logic ident_timeout,
   input wire logic ident_done,
   input wire logic [1:0] oob_rx,
   input wire logic oob_tx_done,
   input wire logic snw_ok,
   input wire logic snw_fail,
   input wire logic [31:0] peer_caps,
   input wire logic peer_caps_vld,
   input wire logic train_ok,
   input wire logic train_fail,
   input wire logic [7:0] max_rate_cfg,
   output logic [1:0] oob_tx,
   output logic dc_idle,
   output logic [31:0] caps_tx,
   output logic snw_start,
   output logic train_start,
   output logic [2:0] train_setting,
   output logic tx_train_en,
   output logic [1:0] rate_max,
   output logic ident_start,
   output logic link_up,
   output logic fw_fail,
   output logic hard_reset_tx,
   output logic res_reinit,
   output logic cmd_abort,
   output logic ua_bus_reset,
   output logic ua_dev_reset
);
   spn_pkg::spn_state_t st_ff, nxt_st;
   logic [1:0] oob_tx_ff, nxt_oob_tx;
   logic [7:0] tried_ff, nxt_tried;
   logic [7:0] common_ff;
   logic [2:0] set_ff;
   logic [spn_pkg::CNT_W-1:0] cnt_ff;
   logic por_ff, hr_pend_ff, cominit_sent_ff;
   logic snw_start_ff, train_start_ff, ident_start_ff, fw_fail_ff;
   logic link_up_ff, reinit_ff, abort_ff, ua_bus_ff, ua_dev_ff, ttx_ff;
   logic [1:0] rate_max_ff;
   logic s1_ff, s2_ff, i1_ff, i2_ff;
   logic found;
   logic [2:0] best;

   // sync_lost and ident_timeout may come off the link side: two stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         i1_ff <= 1'b0;
         i2_ff <= 1'b0;
      end else begin
         s1_ff <= sync_lost;
         s2_ff <= s1_ff;
         i1_ff <= ident_timeout;
         i2_ff <= i1_ff;
      end
   end

   // capability word: start 1, down-spread, llr 0, all settings, even parity
   wire [29:0] cap_body = {1'b0, 2'b00, spn_pkg::CAP_LLR_VAL, // see [RULE16] see [RULE17]
                           spn_pkg::CAP_SETTINGS_ALL, 8'h00, 7'h00}; // see [RULE18] see [RULE25]
   // parity is a one when start plus body hold an odd count, so the total is even
   wire cap_par = ^{1'b1, cap_body}; // see [RULE19]
   wire [31:0] cap_word = {1'b1, cap_body, cap_par}; // see [RULE15]

   // reserved peer bits masked off: only byte 1 settings decide
   wire [7:0] peer_set = peer_caps[23:16]; // see [RULE25]
   // our setting index 0 = g4 ssc .. 7 = g1 no ssc; byte1 bit0 = g4 ssc
   wire [7:0] rate_ok;
   assign rate_ok[1:0] = (rate_max_ff >= 2'h3) ? 2'b11 : 2'b00; // see [RULE13]
   assign rate_ok[3:2] = (rate_max_ff >= 2'h2) ? 2'b11 : 2'b00;
   assign rate_ok[5:4] = (rate_max_ff >= 2'h1) ? 2'b11 : 2'b00;
   assign rate_ok[7:6] = 2'b11;
   wire [7:0] peer_idx = {peer_set[7], peer_set[6], peer_set[5], peer_set[4],
                          peer_set[3], peer_set[2], peer_set[1], peer_set[0]};
   wire [7:0] cand = common_ff & ~tried_ff;
   // common set of this exchange, usable in the very cycle the word arrives
   wire [7:0] common_new = peer_idx & rate_ok;
   wire caps_here = (st_ff == spn_pkg::SPN_SNW) && peer_caps_vld;
   wire [7:0] common_nxt = caps_here ? common_new : common_ff;
   logic dc_idle_ff;

   spn_sel u_sel (
      .cand(cand),
      .found(found),
      .idx(best)
   );

   wire [1:0] cfg_rate = (max_rate_cfg >= 8'h0B) ? spn_pkg::RATE_G4 :
                         (max_rate_cfg == 8'h0A) ? 2'h2 :
                         (max_rate_cfg == 8'h09) ? 2'h1 : spn_pkg::RATE_G1;
   wire cnt_out = (cnt_ff == '0);
   wire new_cominit = por_ff | hr_pend_ff | s2_ff | i2_ff; // see [RULE12] see [RULE9]
   wire peer_init = (oob_rx == spn_pkg::OOB_COMINIT);

   always_comb begin
      nxt_st = st_ff;
      nxt_oob_tx = spn_pkg::OOB_NONE;
      nxt_tried = tried_ff;
      case (st_ff)
         spn_pkg::SPN_IDLE: begin
            // one cominit only after por, hard reset, sync loss or identify timeout; none otherwise
            if (new_cominit && !cominit_sent_ff) begin // see [RULE23]
               nxt_oob_tx = spn_pkg::OOB_COMINIT; // see [RULE11]
               nxt_st = spn_pkg::SPN_OOB;
            end else if (peer_init) begin
               nxt_st = spn_pkg::SPN_OOB;
            end
         end
         spn_pkg::SPN_OOB: begin
            // oob engine sends comsas / comwake; negotiation only after it
            if (oob_rx == spn_pkg::OOB_COMSAS)
               nxt_oob_tx = spn_pkg::OOB_COMSAS; // see [RULE11]
            else if (oob_rx == spn_pkg::OOB_COMWAKE)
               nxt_oob_tx = spn_pkg::OOB_COMWAKE;
            if (oob_tx_done) begin
               nxt_st = spn_pkg::SPN_SNW; // see [RULE1]
               nxt_tried = 8'h00;
            end
         end
         spn_pkg::SPN_SNW: begin
            if (snw_fail || cnt_out) nxt_st = spn_pkg::SPN_FAIL; // see [RULE24]
            else if (snw_ok && peer_caps_vld) begin
               if (common_new == 8'h00) nxt_st = spn_pkg::SPN_FAIL; // see [RULE24]
               else nxt_st = spn_pkg::SPN_TRAIN; // see [RULE14]
            end
         end
         spn_pkg::SPN_TRAIN: begin
            if (train_ok) begin
               nxt_st = spn_pkg::SPN_IDENT; // see [RULE2]
            end else if (train_fail || cnt_out) begin
               nxt_tried = tried_ff | (8'h01 << set_ff); // see [RULE21]
               if ((cand & ~(8'h01 << set_ff)) == 8'h00)
                  nxt_st = spn_pkg::SPN_FAIL; // see [RULE24]
            end
         end
         spn_pkg::SPN_IDENT: begin
            if (ident_done) nxt_st = spn_pkg::SPN_UP;
         end
         spn_pkg::SPN_UP: begin
         end
         spn_pkg::SPN_FAIL: begin
            // dc idle until the far end starts again
            if (peer_init) nxt_st = spn_pkg::SPN_OOB;
         end
         default: nxt_st = spn_pkg::SPN_IDLE;
      endcase
      // hard reset, sync loss or identify timeout restart the link
      if (hard_reset_rx) nxt_st = spn_pkg::SPN_IDLE; // see [RULE3]
      else if (st_ff != spn_pkg::SPN_IDLE && (s2_ff || i2_ff))
         nxt_st = spn_pkg::SPN_IDLE; // see [RULE12]
   end

   wire enter_train = (nxt_st == spn_pkg::SPN_TRAIN) &&
                      (st_ff != spn_pkg::SPN_TRAIN || nxt_tried != tried_ff);
   wire [7:0] cand_nxt = common_nxt & ~nxt_tried;
   logic [2:0] nxt_set;
   always_comb begin
      nxt_set = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (cand_nxt[i]) nxt_set = 3'(i); // see [RULE20] see [RULE22]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= spn_pkg::SPN_IDLE;
         oob_tx_ff <= spn_pkg::OOB_NONE;
         tried_ff <= 8'h00;
         common_ff <= 8'h00;
         set_ff <= 3'h0;
         cnt_ff <= '0;
         rate_max_ff <= spn_pkg::RATE_G4;
      end else begin
         st_ff <= nxt_st;
         oob_tx_ff <= nxt_oob_tx;
         tried_ff <= nxt_tried;
         rate_max_ff <= cfg_rate; // see [RULE13]
         common_ff <= common_nxt; // see [RULE20]
         if (enter_train) set_ff <= nxt_set;
         if (nxt_st == spn_pkg::SPN_SNW && st_ff != spn_pkg::SPN_SNW)
            cnt_ff <= spn_pkg::CNT_W'(spn_pkg::SNW_WIN_CYC);
         else if (enter_train)
            cnt_ff <= spn_pkg::CNT_W'(spn_pkg::TRAIN_CYC);
         else if (!cnt_out)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end

   // hard reset bookkeeping; one-shot cominit for por and hard reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         por_ff <= 1'b1;
         hr_pend_ff <= 1'b0;
         cominit_sent_ff <= 1'b0;
         reinit_ff <= 1'b0;
         abort_ff <= 1'b0;
         ua_bus_ff <= 1'b0;
         ua_dev_ff <= 1'b0;
      end else begin
         if (nxt_oob_tx == spn_pkg::OOB_COMINIT) begin
            por_ff <= 1'b0;
            hr_pend_ff <= 1'b0;
            cominit_sent_ff <= 1'b1;
         end else if (st_ff == spn_pkg::SPN_UP) begin
            cominit_sent_ff <= 1'b0;
         end
         // restart cause is a one-cycle pulse: keep it until the cominit goes out
         if (hard_reset_done || s2_ff || i2_ff) hr_pend_ff <= 1'b1; // see [RULE9] see [RULE12]
         if (s2_ff || i2_ff || hard_reset_done) cominit_sent_ff <= 1'b0;
         reinit_ff <= hard_reset_rx; // see [RULE5]
         // other port's hard reset aborts ours but keeps our link
         abort_ff <= hard_reset_rx | other_hard_reset; // see [RULE4]
         ua_bus_ff <= hard_reset_rx; // see [RULE6]
         ua_dev_ff <= other_hard_reset; // see [RULE7]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         snw_start_ff <= 1'b0;
         train_start_ff <= 1'b0;
         ident_start_ff <= 1'b0;
         fw_fail_ff <= 1'b0;
         link_up_ff <= 1'b0;
         ttx_ff <= 1'b0;
         dc_idle_ff <= 1'b0;
      end else begin
         dc_idle_ff <= (nxt_st == spn_pkg::SPN_FAIL); // see [RULE24]
         snw_start_ff <= (nxt_st == spn_pkg::SPN_SNW) && (st_ff != spn_pkg::SPN_SNW);
         train_start_ff <= enter_train;
         // tx training only on the two 12g settings
         if (enter_train) ttx_ff <= (nxt_set < 3'h2); // see [RULE14]
         ident_start_ff <= (nxt_st == spn_pkg::SPN_IDENT) && (st_ff != spn_pkg::SPN_IDENT);
         fw_fail_ff <= (nxt_st == spn_pkg::SPN_FAIL) && (st_ff != spn_pkg::SPN_FAIL);
         link_up_ff <= (nxt_st == spn_pkg::SPN_UP);
      end
   end

   assign oob_tx = oob_tx_ff; // see [RULE10]
   assign dc_idle = dc_idle_ff;
   assign caps_tx = cap_word;
   assign snw_start = snw_start_ff;
   assign train_start = train_start_ff;
   assign train_setting = set_ff;
   assign tx_train_en = ttx_ff;
   assign rate_max = rate_max_ff;
   assign ident_start = ident_start_ff;
   assign link_up = link_up_ff;
   assign fw_fail = fw_fail_ff;
   assign hard_reset_tx = 1'b0; // see [RULE8]
   assign res_reinit = reinit_ff;
   assign cmd_abort = abort_ff;
   assign ua_bus_reset = ua_bus_ff;
   assign ua_dev_reset = ua_dev_ff;

   // assertions
   a_no_hard_reset: assert property (@(posedge clk) disable iff (!rst_n)
      hard_reset_tx == 1'b0) else $error("hard reset transmitted"); // see [RULE8]
   a_ident_after_train: assert property (@(posedge clk) disable iff (!rst_n)
      ident_start |-> $past(st_ff) == spn_pkg::SPN_TRAIN) else $error("identify early"); // see [RULE2]
   a_snw_after_oob: assert property (@(posedge clk) disable iff (!rst_n)
      snw_start |-> $past(st_ff) == spn_pkg::SPN_OOB) else $error("snw without oob"); // see [RULE1]
   a_caps_parity: assert property (@(posedge clk) disable iff (!rst_n)
      ^caps_tx == 1'b0 && caps_tx[31] && !caps_tx[30]) else $error("caps word bad"); // see [RULE19]
   a_fail_flag: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(fw_fail) |-> st_ff == spn_pkg::SPN_FAIL) else $error("fail flag wrong"); // see [RULE24]
   a_ua_bus: assert property (@(posedge clk) disable iff (!rst_n)
      hard_reset_rx |=> ua_bus_reset && cmd_abort) else $error("no unit attention"); // see [RULE6]
   a_ua_dev: assert property (@(posedge clk) disable iff (!rst_n)
      other_hard_reset |=> ua_dev_reset && cmd_abort) else $error("no dev reset flag"); // see [RULE7]
   a_tx_train_g4: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(train_start) |-> tx_train_en == (train_setting < 3'h2)) else $error("tx train rate"); // see [RULE14]
endmodule
`default_nettype wire

// File: rtl/spn_pkg.sv
// constants and types for the port link bring-up block
//
// Function
// [RULE1] phy reset is out-of-band phase then speed negotiation, in order
// [RULE2] link reset is phy reset then identification, never identification early
// [RULE3] optional hard reset follows a phy reset, then another phy reset and identify
// [RULE4] hard reset on this port leaves other link alone, aborts its commands
// [RULE5] hard reset reinitialises all device resources like power-on reset
// [RULE6] first command per initiator here: unit attention, bus reset occurred
// [RULE7] first command per initiator on other port: bus device reset occurred
// [RULE8] device never transmits a hard reset sequence on either port
// [RULE9] after hard reset processing the device starts a link reset on that port
// [RULE10] oob signal is dc idle and align bursts, typed by idle length
// [RULE11] generate and recognise cominit, comwake and comsas
// [RULE12] send cominit on power-on, loss of dword sync, identify timeout
// [RULE13] rates 1.5 to 12 gbps, default max 12, config byte lowers it
// [RULE14] run snw-1, snw-2, snw-3; rx training always, tx training at 12g only
// [RULE15] capabilities byte 0 bit 7 start bit is one
// [RULE16] capabilities byte 0 bit 6 ssc type is zero, down-spreading
// [RULE17] requested logical link rate field in byte 0 is zero
// [RULE18] capabilities byte 1 advertises all eight settings as one
// [RULE19] byte 3 bit 0 parity makes total ones count even
// [RULE20] train first with highest priority common untried setting
// [RULE21] on invalid training retry with next highest common untried setting
// [RULE22] priority g4 ssc, g4, g3 ssc, g3, g2 ssc, g2, g1 ssc, g1
// [RULE23] after power-on or hard reset send exactly one cominit, else none
// [RULE24] no common rate or failed retry: flag firmware, dc idle, await cominit
// [RULE25] reserved capability bits sent zero and ignored on reception
package spn_pkg;
   localparam int CLK_MHZ = 250;
   // timeouts in microseconds, cycles derived
   localparam int SNW_WIN_US = 10;
   localparam int SNW_WIN_CYC = SNW_WIN_US * CLK_MHZ;
   localparam int TRAIN_US = 15;
   localparam int TRAIN_CYC = TRAIN_US * CLK_MHZ;
   localparam int CNT_W = 16;
   // oob signal codes on the oob engine port
   localparam logic [1:0] OOB_NONE = 2'h0;
   localparam logic [1:0] OOB_COMINIT = 2'h1;
   localparam logic [1:0] OOB_COMWAKE = 2'h2;
   localparam logic [1:0] OOB_COMSAS = 2'h3;
   // capability word bit fields (byte 0 at [31:24])
   localparam int CAP_START_BIT = 31;
   localparam int CAP_SSC_TYPE_BIT = 30;
   localparam logic [3:0] CAP_LLR_VAL = 4'h0;
   localparam logic [7:0] CAP_SETTINGS_ALL = 8'hFF;
   localparam int CAP_PARITY_BIT = 0;
   localparam logic [7:0] MAX_RATE_RST = 8'h0B; // 12 gbps rate code
   localparam logic [1:0] RATE_G1 = 2'h0;
   localparam logic [1:0] RATE_G4 = 2'h3;
   typedef enum logic [2:0] {
      SPN_IDLE  = 3'h0,
      SPN_OOB   = 3'h1,
      SPN_SNW   = 3'h3,
      SPN_TRAIN = 3'h2,
      SPN_IDENT = 3'h6,
      SPN_UP    = 3'h7,
      SPN_FAIL  = 3'h5
   } spn_state_t;
endpackage

// File: rtl/spn_sel.sv
// picks highest priority common untried training setting
`timescale 1ns/1ps
`default_nettype none
module spn_sel (
   input wire logic [7:0] cand,
   output logic found,
   output logic [2:0] idx
);
   // bit 0 is g4 with ssc: lowest index wins
   always_comb begin
      found = 1'b0;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (cand[i]) begin
            found = 1'b1;
            idx = 3'(i);
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/spn_peer_model.sv
// far-side link phy model answering oob, negotiation, training, identify
`timescale 1ns/1ps
`default_nettype none
module spn_peer_model (
   input wire logic clk,
   input wire logic [1:0] oob_tx,
   input wire logic snw_start,
   input wire logic train_start,
   input wire logic [2:0] train_setting,
   input wire logic ident_start,
   input wire logic [7:0] caps,
   input wire logic [7:0] fmask,
   input wire logic bad,
   input wire logic rsv,
   input wire logic [7:0] dly,
   output logic [1:0] oob_rx,
   output logic oob_tx_done,
   output logic snw_ok,
   output logic snw_fail,
   output logic [31:0] peer_caps,
   output logic peer_caps_vld,
   output logic train_ok,
   output logic train_fail,
   output logic ident_done
);
   logic [31:0] word;
   logic [2:0] set_q;
   // reserved bits may be set on purpose to prove they are ignored
   assign word[31:1] = {rsv ? 8'hBF : 8'h80, caps, rsv ? 15'h7FFF : 15'h0000};
   assign word[0] = ^word[31:1];
   initial begin
      {oob_rx, oob_tx_done, snw_ok, snw_fail, peer_caps_vld} = 6'h00;
      {train_ok, train_fail, ident_done} = 3'h0;
      peer_caps = 32'h5A5A5A5A;
   end
   // requests sampled on the falling edge, clear of the design's updates
   task automatic wait_dly();
      repeat (dly) @(posedge clk);
      @(posedge clk) #1;
   endtask
   always @(negedge clk) begin
      if (oob_tx == spn_pkg::OOB_COMINIT) begin
         wait_dly();
         oob_rx = spn_pkg::OOB_COMSAS;
         @(posedge clk) #1;
         oob_rx = spn_pkg::OOB_NONE;
         oob_tx_done = 1'b1;
         @(posedge clk) #1;
         oob_tx_done = 1'b0;
      end
   end
   always @(negedge clk) begin
      if (snw_start) begin
         wait_dly();
         peer_caps = word;
         {peer_caps_vld, snw_ok, snw_fail} = {!bad, !bad, bad};
         @(posedge clk) #1;
         peer_caps = ~word;
         {peer_caps_vld, snw_ok, snw_fail} = 3'h0;
      end
   end
   always @(negedge clk) begin
      if (train_start) begin
         set_q = train_setting;
         wait_dly();
         {train_fail, train_ok} = {fmask[set_q], !fmask[set_q]};
         @(posedge clk) #1;
         {train_fail, train_ok} = 2'h0;
      end
   end
   always @(negedge clk) begin
      if (ident_start) begin
         wait_dly();
         ident_done = 1'b1;
         @(posedge clk) #1;
         ident_done = 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the link bring-up sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk, rst_n, hard_reset_rx, hard_reset_done, other_hard_reset, sync_lost;
   logic ident_timeout, ident_done, oob_tx_done, snw_ok, snw_fail, peer_caps_vld;
   logic train_ok, train_fail, dc_idle, snw_start, train_start, tx_train_en, ident_start;
   logic link_up, fw_fail, hard_reset_tx, res_reinit, cmd_abort, ua_bus_reset, ua_dev_reset;
   logic [1:0] oob_rx, oob_tx, rate_max;
   logic [2:0] train_setting;
   logic [31:0] peer_caps, caps_tx;
   logic [7:0] max_rate_cfg, caps, fmask, dly;
   logic bad, rsv;
   logic [3:0] got;
   int err_total, tests_run, cyc, n;
   spn_link_reset i_dut (.clk, .rst_n, .hard_reset_rx, .hard_reset_done, .other_hard_reset,
      .sync_lost, .ident_timeout, .ident_done, .oob_rx, .oob_tx_done, .snw_ok, .snw_fail,
      .peer_caps, .peer_caps_vld, .train_ok, .train_fail, .max_rate_cfg, .oob_tx, .dc_idle,
      .caps_tx, .snw_start, .train_start, .train_setting, .tx_train_en, .rate_max,
      .ident_start, .link_up, .fw_fail, .hard_reset_tx, .res_reinit, .cmd_abort,
      .ua_bus_reset, .ua_dev_reset);
   spn_peer_model i_peer (.clk, .oob_tx, .snw_start, .train_start, .train_setting,
      .ident_start, .caps, .fmask, .bad, .rsv, .dly, .oob_rx, .oob_tx_done, .snw_ok,
      .snw_fail, .peer_caps, .peer_caps_vld, .train_ok, .train_fail, .ident_done);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         final_report();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // trig: 0 power-on, 1 sync loss, 2 identify timeout, 3 hard reset done
   task automatic run_link(input string name, input int trig, input logic up, input int lo);
      int n_init, n_id, n_fail, n_bad, n_ord, nx;
      logic oob_seen;
      {n_init, n_id, n_fail, n_bad, n_ord} = '0;
      nx = lo;
      oob_seen = 1'b0;
      sync_lost = (trig == 1);
      ident_timeout = (trig == 2);
      hard_reset_done = (trig == 3);
      for (int k = 0; k < 20000 && (k < 8 || (link_up !== 1'b1 && n_fail == 0)); k++) begin
         @(posedge clk) #1;
         {sync_lost, ident_timeout, hard_reset_done} = 3'h0;
         n_init += (oob_tx == spn_pkg::OOB_COMINIT);
         n_bad += (hard_reset_tx !== 1'b0);
         n_id += (ident_start === 1'b1);
         n_fail += (fw_fail === 1'b1);
         oob_seen |= (oob_tx_done === 1'b1);
         n_ord += (snw_start === 1'b1 && !oob_seen);
         if (train_start === 1'b1) begin
            while (nx < 7 && !caps[nx]) nx++;
            chk("train_setting", train_setting, nx);
            chk("tx_train_en", tx_train_en, nx < 2);
            nx++;
         end
      end
      chk("cominit count", n_init, 1);
      chk("oob before snw", n_ord, 0);
      chk("link_up", link_up, up);
      chk("ident_start count", n_id, up);
      chk("fw_fail count", n_fail, !up);
      chk("dc_idle", dc_idle, !up);
      chk("hard_reset_tx", n_bad, 0);
      $display("test %s done", name);
   endtask
   task automatic hit(input logic oth);
      got = 4'h0;
      other_hard_reset = oth;
      hard_reset_rx = !oth;
      repeat (4) begin
         @(posedge clk) #1;
         {other_hard_reset, hard_reset_rx} = 2'h0;
         got = got | {res_reinit, cmd_abort, ua_bus_reset, ua_dev_reset};
      end
   endtask
   initial begin
      {rst_n, hard_reset_rx, hard_reset_done, other_hard_reset} = 4'h0;
      {sync_lost, ident_timeout, bad, rsv} = 4'h0;
      {max_rate_cfg, caps, fmask, dly} = {8'h0B, 8'hFF, 8'h00, 8'h02};
      {err_total, tests_run, cyc} = '0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      chk("rate_max", rate_max, 2'h3);
      chk("caps_tx", caps_tx, 32'h80FF0001);
      run_link("power-on", 0, 1'b1, 0);
      // slow peer, reserved bits set, two settings fail before the third
      {caps, fmask, rsv, dly} = {8'hA4, 8'h24, 1'b1, 8'h28};
      run_link("retry order", 1, 1'b1, 0);
      {caps, fmask, rsv, dly} = {8'h03, 8'hFF, 1'b0, 8'h02};
      run_link("all fail", 2, 1'b0, 0);
      caps = 8'h00;
      run_link("no common", 1, 1'b0, 0);
      {caps, bad} = {8'hFF, 1'b1};
      run_link("snw fail", 1, 1'b0, 0);
      {bad, fmask, max_rate_cfg} = {1'b0, 8'h00, 8'h09};
      repeat (3) @(posedge clk);
      #1 chk("rate_max", rate_max, 2'h1);
      run_link("rate cap", 1, 1'b1, 4);
      max_rate_cfg = 8'h0B;
      hit(1'b1);
      chk("other port", {got[2:0], link_up}, 4'hB);
      hit(1'b0);
      chk("own port", {got[3], got[1], got[0], link_up}, 4'hC);
      n = 0;
      repeat (20) begin
         @(posedge clk) #1;
         n += (oob_tx == spn_pkg::OOB_COMINIT);
      end
      chk("early cominit", n, 0);
      run_link("hard reset", 3, 1'b1, 0);
      final_report();
   end
endmodule
`default_nettype wire
